/* File: common/gsc_pkg.sv */
/*
 * constants, character codes, field table and state types of the sensor command interpreter.
 * assumes 8-bit ascii bytes and a 32-bit classic wishbone register port.
 */
package gsc_pkg;
   // character codes
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_LF = 8'h0a;
   localparam logic [7:0] CH_SP = 8'h20;
   localparam logic [7:0] CH_COMMA = 8'h2c;
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_9 = 8'h39;
   localparam logic [7:0] CH_B = 8'h42;
   localparam logic [7:0] CH_M = 8'h4d;
   localparam logic [7:0] CH_Q = 8'h51;
   localparam logic [7:0] CH_US = 8'h53;
   localparam logic [7:0] CH_Y = 8'h59;
   localparam logic [7:0] CH_LS = 8'h73;

   // value widths and limits
   localparam int VW = 17;
   localparam int NDIG = 5;
   localparam int NFLD = 9;
   localparam int MAX_FIELDS = 5;
   localparam logic [2:0] LAST_DIG = 3'h4;
   localparam logic [2:0] ARG_DIGITS = 3'h5;
   localparam logic [4:0] FMT_LAST = 5'h10;
   localparam logic [16:0] RST_MASK = 17'h00006;
   localparam logic [16:0] RST_COMP = 17'h02000;
   localparam logic [16:0] COMP_MAX = 17'h10000;

   // field table, index 0 has the highest mask weight
   localparam logic [8:0][3:0] FLD_BIT = {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'ha, 4'hb};
   localparam logic [8:0][7:0] FLD_ID = {8'h5a, 8'h5a, 8'h56, 8'h30, 8'h30, 8'h56, 8'h68, 8'h44, 8'h64};
   localparam logic [3:0] FLD_NONE = 4'h9;

   // register byte offsets
   localparam logic [7:0] ADDR_MASK = 8'h00;
   localparam logic [7:0] ADDR_COMP = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;

   typedef enum logic [1:0] {P_CMD, P_ARG, P_LF, P_SKIP} gsc_prs_t;
   typedef enum logic [3:0] {E_IDLE, E_HEAD, E_SPACE, E_CONV, E_DIGIT, E_NEXT, E_SEP, E_TEXT, E_CR, E_LF} gsc_emit_t;
endpackage : gsc_pkg

/* File: common/gsc_fmt_if.sv */
/*
 * carrier between the interpreter and its decimal formatter.
 * assumes both ends run on the same clock.
 */
interface gsc_fmt_if;
   logic start;
   logic [16:0] value;
   logic done;
   logic [19:0] bcd;
   modport conv (input start, input value, output done, output bcd);
   modport user (output start, output value, input done, input bcd);
endinterface : gsc_fmt_if

/* File: core/gsc_dec_fmt.sv */
/*
 * binary to five-digit decimal converter, shift-and-add-three, one bit per cycle.
 * assumes the value is below 100000 and start is a one-cycle pulse.
 */
module gsc_dec_fmt (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // request and result
   gsc_fmt_if.conv fmt
);
   logic [36:0] sh_q;
   logic [4:0] cnt_q;
   logic run_q;
   logic done_q;
   wire [19:0] adj;

   genvar g;
   generate
      for (g = 0; g < gsc_pkg::NDIG; g++) begin : g_adj
         wire [3:0] nib = sh_q[17 + 4 * g +: 4];
         assign adj[4 * g +: 4] = (nib >= 4'h5) ? 4'(nib + 4'h3) : nib;
      end
   endgenerate

   wire [36:0] sh_nxt = {adj[18:0], sh_q[16:0], 1'b0};

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sh_q <= '0;
         cnt_q <= '0;
         run_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (fmt.start) begin
            sh_q <= {20'h00000, fmt.value};
            cnt_q <= '0;
            run_q <= 1'b1;
         end else if (run_q) begin
            sh_q <= sh_nxt;
            cnt_q <= 5'(cnt_q + 5'h01);
            if (cnt_q == gsc_pkg::FMT_LAST) begin
               run_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end

   // digits stay valid until the next start
   assign fmt.done = done_q;
   assign fmt.bcd = sh_q[36:17];
endmodule : gsc_dec_fmt

/* File: core/gsc_cmd_top.sv */
/*
 * ascii command interpreter of a gas sensor: s, S, M, Q and Y commands, wishbone registers.
 * assumes byte streams from and to a uart on the same clock, and measurement values from
 * same-clock logic.
 */
// The implementer's own choices: register access over Wishbone and the register addresses.
// Functional notes
// - s CR LF answers s, space, compensation as five digits, CR LF.
// - one output line carries at most five fields, chosen by the mask.
// - each field is identifier, one space, five decimal digits.
// - weight 2048 gives d, 1024 gives D, 256 gives h.
// - weights 128 and 8 give temperature values, identifier V.
// - weights 32 and 16 give light-source strength, identifier zero.
// - weights 4 and 2 give filtered and raw concentration, identifier Z.
// - mask is a sum of weights; each weight is one independent bit.
// - M, space, up to five digits, CR LF stores mask and echoes it.
// - after reset the mask selects both concentration fields.
// - Q CR LF returns latest values of the enabled fields, CR LF.
// - Y CR LF returns an identity line and a serial line.
// - compensation stored by S, range 0 to 65536, reset 8192.
module gsc_cmd_top #(
   parameter logic [159:0] FW_STAMP = "Jan 01 2000,00:00:00", // arbitrary value
   parameter logic [55:0] FW_REV = "REV0001", // arbitrary value
   parameter logic [47:0] SENSOR_ID = "000001", // arbitrary value
   parameter int MAX_FIELDS = gsc_pkg::MAX_FIELDS
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // received bytes
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   output logic rx_ready,
   // transmitted bytes
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   // latest measurement values, index 0 has the highest mask weight
   input wire logic [gsc_pkg::NFLD-1:0][15:0] fld_val
);
   localparam int L1 = 3 + $bits(FW_STAMP) / 8 + $bits(FW_REV) / 8;
   localparam int L2 = 8 + $bits(SENSOR_ID) / 8;
   localparam logic [8*L1-1:0] LINE1 = {gsc_pkg::CH_Y, gsc_pkg::CH_COMMA, FW_STAMP, gsc_pkg::CH_COMMA, FW_REV};
   localparam logic [8*L2-1:0] LINE2 = {gsc_pkg::CH_B, gsc_pkg::CH_SP, SENSOR_ID, gsc_pkg::CH_SP, {5{gsc_pkg::CH_0}}};

   gsc_pkg::gsc_prs_t p_q, p_d;
   gsc_pkg::gsc_emit_t e_q, e_d;
   logic [7:0] cmd_q, cmd_d, hd_q, hd_d, td_q, td_d;
   logic [16:0] acc_q, acc_d, mask_q, mask_d, comp_q, comp_d;
   logic [2:0] nd_q, nd_d, dig_q, dig_d, fcnt_q, fcnt_d;
   logic [3:0] fsel_q, fsel_d, fptr_q, fptr_d;
   logic [5:0] tix_q, tix_d;
   logic bad_q, bad_d, line_q, line_d, tv_q, tv_d, rdy_q, ack_q, first_q;
   logic [31:0] dat_q;
   logic exec, start, em;
   logic [7:0] ch;
   gsc_pkg::gsc_emit_t nx;

   gsc_fmt_if fmt ();

   gsc_dec_fmt u_fmt (
      .clk(clk),
      .arst_n(arst_n),
      .fmt(fmt)
   );

   function automatic logic [16:0] merge(input logic [16:0] o, input logic [31:0] w, input logic [3:0] s);
      return {s[2] ? w[16] : o[16], s[1] ? w[15:8] : o[15:8], s[0] ? w[7:0] : o[7:0]};
   endfunction : merge

   function automatic logic [16:0] clamp_comp(input logic [16:0] v);
      return (v > gsc_pkg::COMP_MAX) ? gsc_pkg::COMP_MAX : v;
   endfunction : clamp_comp

   // lowest index at or after from whose weight bit is set in the mask
   function automatic logic [3:0] first_fld(input logic [16:0] m, input logic [3:0] from);
      logic [3:0] r;
      r = gsc_pkg::FLD_NONE;
      for (int i = gsc_pkg::NFLD - 1; i >= 0; i--) begin
         if (i >= int'(from) && m[gsc_pkg::FLD_BIT[i]]) r = 4'(i);
      end
      return r;
   endfunction : first_fld

   // register bus decode
   wire wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
   wire wr_mask = wb_req & wb_we_i & (wb_adr_i == gsc_pkg::ADDR_MASK);
   wire wr_comp = wb_req & wb_we_i & (wb_adr_i == gsc_pkg::ADDR_COMP);
   wire busy = (e_q != gsc_pkg::E_IDLE);
   wire [31:0] stat = {16'h0000, cmd_q, 6'h00, (p_q == gsc_pkg::P_SKIP), busy};
   wire [31:0] rd_mux = (wb_adr_i == gsc_pkg::ADDR_MASK) ? {15'h0000, mask_q} :
                        (wb_adr_i == gsc_pkg::ADDR_COMP) ? {15'h0000, comp_q} :
                        (wb_adr_i == gsc_pkg::ADDR_STAT) ? stat : 32'h00000000;

   // byte stream decode
   wire rx_fire = rx_valid & rdy_q;
   wire tx_fire = tv_q & tx_ready;
   wire is_dig = (rx_data >= gsc_pkg::CH_0) && (rx_data <= gsc_pkg::CH_9);
   wire known = (rx_data == gsc_pkg::CH_LS) || (rx_data == gsc_pkg::CH_US) || (rx_data == gsc_pkg::CH_M) ||
                (rx_data == gsc_pkg::CH_Q) || (rx_data == gsc_pkg::CH_Y);
   wire [16:0] acc_nxt = 17'({acc_q, 3'b000} + {acc_q, 1'b0} + {13'h0000, rx_data[3:0]});
   wire is_q = (cmd_q == gsc_pkg::CH_Q);
   wire [3:0] nidx = first_fld(mask_q, fptr_q);
   wire [3:0] dig_nib = fmt.bcd[5'h10 - {dig_q, 2'b00} +: 4];
   wire [5:0] tix_last = line_q ? 6'(L2 - 1) : 6'(L1 - 1);
   wire [7:0] txt_ch = line_q ? LINE2[8 * (L2 - 1 - int'(tix_q)) +: 8] : LINE1[8 * (L1 - 1 - int'(tix_q)) +: 8];
   wire [16:0] num_val = (cmd_q == gsc_pkg::CH_M) ? mask_q : is_q ? {1'b0, fld_val[fsel_q]} : comp_q;

   assign mask_d = wr_mask ? merge(mask_q, wb_dat_i, wb_sel_i) :
                   (exec && cmd_q == gsc_pkg::CH_M) ? acc_q : mask_q;
   assign comp_d = wr_comp ? clamp_comp(merge(comp_q, wb_dat_i, wb_sel_i)) :
                   (exec && cmd_q == gsc_pkg::CH_US) ? clamp_comp(acc_q) : comp_q;
   assign fmt.start = start;
   assign fmt.value = num_val;

   // line parser
   always_comb begin
      p_d = p_q;
      cmd_d = cmd_q;
      acc_d = acc_q;
      nd_d = nd_q;
      bad_d = bad_q;
      exec = 1'b0;
      if (rx_fire) begin
         case (p_q)
            gsc_pkg::P_CMD: begin
               if (rx_data == gsc_pkg::CH_CR) begin
                  p_d = gsc_pkg::P_LF;
                  bad_d = 1'b1;
               end else if (known) begin
                  p_d = gsc_pkg::P_ARG;
                  cmd_d = rx_data;
                  acc_d = '0;
                  nd_d = '0;
                  bad_d = 1'b0;
               end else begin
                  p_d = gsc_pkg::P_SKIP;
               end
            end
            gsc_pkg::P_ARG: begin
               if (rx_data == gsc_pkg::CH_CR) begin
                  p_d = gsc_pkg::P_LF;
               end else if (is_dig && nd_q != gsc_pkg::ARG_DIGITS) begin
                  acc_d = acc_nxt;
                  nd_d = 3'(nd_q + 3'h1);
               end else if (rx_data != gsc_pkg::CH_SP) begin
                  bad_d = 1'b1;
               end
            end
            gsc_pkg::P_LF: begin
               if (rx_data == gsc_pkg::CH_LF) begin
                  exec = ~bad_q;
                  p_d = gsc_pkg::P_CMD;
               end else if (rx_data != gsc_pkg::CH_CR) begin
                  p_d = gsc_pkg::P_SKIP;
               end
            end
            gsc_pkg::P_SKIP: begin
               if (rx_data == gsc_pkg::CH_CR) begin
                  p_d = gsc_pkg::P_LF;
                  bad_d = 1'b1;
               end
            end
            default: p_d = gsc_pkg::P_CMD;
         endcase
      end
   end

   // answer emitter; every byte is held until tx_ready, then one idle cycle follows
   always_comb begin
      e_d = e_q;
      hd_d = hd_q;
      dig_d = dig_q;
      fsel_d = fsel_q;
      fptr_d = fptr_q;
      fcnt_d = fcnt_q;
      tix_d = tix_q;
      line_d = line_q;
      tv_d = tv_q;
      td_d = td_q;
      start = 1'b0;
      em = 1'b1;
      ch = gsc_pkg::CH_SP;
      nx = e_q;
      case (e_q)
         gsc_pkg::E_IDLE: begin
            em = 1'b0;
            if (exec) begin
               hd_d = cmd_q;
               fptr_d = '0;
               fcnt_d = '0;
               tix_d = '0;
               line_d = 1'b0;
               e_d = (cmd_q == gsc_pkg::CH_Y) ? gsc_pkg::E_TEXT : is_q ? gsc_pkg::E_NEXT : gsc_pkg::E_HEAD;
            end
         end
         gsc_pkg::E_HEAD: begin
            ch = hd_q;
            nx = gsc_pkg::E_SPACE;
         end
         gsc_pkg::E_SPACE: begin
            nx = gsc_pkg::E_CONV;
            start = tx_fire;
         end
         gsc_pkg::E_CONV: begin
            em = 1'b0;
            dig_d = '0;
            if (fmt.done) e_d = gsc_pkg::E_DIGIT;
         end
         gsc_pkg::E_DIGIT: begin
            ch = {4'h3, dig_nib};
            nx = (dig_q != gsc_pkg::LAST_DIG) ? gsc_pkg::E_DIGIT : is_q ? gsc_pkg::E_NEXT : gsc_pkg::E_CR;
            if (tx_fire) dig_d = 3'(dig_q + 3'h1);
         end
         gsc_pkg::E_NEXT: begin
            em = 1'b0;
            if (nidx != gsc_pkg::FLD_NONE && int'(fcnt_q) < MAX_FIELDS) begin
               fsel_d = nidx;
               fptr_d = 4'(nidx + 4'h1);
               hd_d = gsc_pkg::FLD_ID[nidx];
               fcnt_d = 3'(fcnt_q + 3'h1);
               e_d = (fcnt_q == 3'h0) ? gsc_pkg::E_HEAD : gsc_pkg::E_SEP;
            end else begin
               e_d = gsc_pkg::E_CR;
            end
         end
         gsc_pkg::E_SEP: nx = gsc_pkg::E_HEAD;
         gsc_pkg::E_TEXT: begin
            ch = txt_ch;
            nx = (tix_q == tix_last) ? gsc_pkg::E_CR : gsc_pkg::E_TEXT;
            if (tx_fire) tix_d = 6'(tix_q + 6'h01);
         end
         gsc_pkg::E_CR: begin
            ch = gsc_pkg::CH_CR;
            nx = gsc_pkg::E_LF;
         end
         gsc_pkg::E_LF: begin
            ch = gsc_pkg::CH_LF;
            nx = (cmd_q == gsc_pkg::CH_Y && !line_q) ? gsc_pkg::E_TEXT : gsc_pkg::E_IDLE;
            if (tx_fire && cmd_q == gsc_pkg::CH_Y) begin
               line_d = 1'b1;
               tix_d = '0;
            end
         end
         default: begin
            em = 1'b0;
            e_d = gsc_pkg::E_IDLE;
         end
      endcase
      if (em && !tv_q) begin
         tv_d = 1'b1;
         td_d = ch;
      end else if (em && tx_fire) begin
         tv_d = 1'b0;
         e_d = nx;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         p_q <= gsc_pkg::P_CMD;
         e_q <= gsc_pkg::E_IDLE;
         {cmd_q, hd_q, td_q} <= '0;
         {acc_q, nd_q, dig_q, fcnt_q, fsel_q, fptr_q, tix_q} <= '0;
         {bad_q, line_q, tv_q, rdy_q, ack_q} <= '0;
         mask_q <= gsc_pkg::RST_MASK;
         comp_q <= gsc_pkg::RST_COMP;
         dat_q <= '0;
         first_q <= 1'b1;
      end else begin
         // enum state registers are assigned on their own; a concatenated target would cast bits into them
         p_q <= p_d;
         e_q <= e_d;
         {cmd_q, acc_q, nd_q, bad_q} <= {cmd_d, acc_d, nd_d, bad_d};
         {hd_q, dig_q, fsel_q, fptr_q, fcnt_q} <= {hd_d, dig_d, fsel_d, fptr_d, fcnt_d};
         {tix_q, line_q, tv_q, td_q} <= {tix_d, line_d, tv_d, td_d};
         mask_q <= mask_d;
         comp_q <= comp_d;
         rdy_q <= (e_d == gsc_pkg::E_IDLE);
         ack_q <= wb_req;
         if (wb_req) dat_q <= rd_mux;
         first_q <= 1'b0;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign rx_ready = rdy_q;
   assign tx_valid = tv_q;
   assign tx_data = td_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   chk_reset_values: assert property (first_q |-> mask_q == gsc_pkg::RST_MASK && comp_q == gsc_pkg::RST_COMP)
      else $error("mask or compensation wrong after reset");
   chk_mask_echo: assert property (exec && cmd_q == gsc_pkg::CH_M && !wr_mask |=> mask_q == $past(acc_q)
      ##1 (tv_q && td_q == gsc_pkg::CH_M))
      else $error("mask not stored or not echoed");
   chk_comp_range: assert property (comp_q <= gsc_pkg::COMP_MAX)
      else $error("compensation out of range");
   chk_head_cmd: assert property (tx_fire && e_q == gsc_pkg::E_HEAD && !is_q |-> td_q == cmd_q)
      else $error("answer does not start with the command");
   chk_field_enabled: assert property (tx_fire && e_q == gsc_pkg::E_HEAD && is_q
      |-> mask_q[gsc_pkg::FLD_BIT[fsel_q]] && td_q == gsc_pkg::FLD_ID[fsel_q])
      else $error("field sent that the mask does not enable");
   chk_field_limit: assert property (int'(fcnt_q) <= MAX_FIELDS)
      else $error("more fields than allowed");
   chk_digit_char: assert property (tx_fire && e_q == gsc_pkg::E_DIGIT
      |-> td_q >= gsc_pkg::CH_0 && td_q <= gsc_pkg::CH_9)
      else $error("non-digit in a number");
   chk_cr_then_lf: assert property (tx_fire && td_q == gsc_pkg::CH_CR
      |=> !tv_q ##1 (tv_q && td_q == gsc_pkg::CH_LF))
      else $error("carriage return not followed by line feed");
   chk_skip_silent: assert property (p_q == gsc_pkg::P_SKIP |-> !exec ##1 !exec)
      else $error("discarded line was executed");
   chk_ident_lines: assert property (tx_fire && e_q == gsc_pkg::E_TEXT && tix_q == 6'h00
      |-> td_q == (line_q ? gsc_pkg::CH_B : gsc_pkg::CH_Y))
      else $error("identity line has the wrong lead");

   cov_poll_fields: cover property (tx_fire && e_q == gsc_pkg::E_SEP);
   cov_ident_done: cover property (tx_fire && e_q == gsc_pkg::E_LF && line_q);
   cov_mask_cmd: cover property (exec && cmd_q == gsc_pkg::CH_M);
   cov_skip_line: cover property (p_q == gsc_pkg::P_SKIP ##1 p_q == gsc_pkg::P_LF);
endmodule : gsc_cmd_top

/* File: verification/gsc_host_model.sv */
/*
 * host model: sends command lines on the receive stream and collects reply bytes.
 * assumes the interpreter takes a byte on an edge where valid and ready are both high.
 */
module gsc_host_model (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // reply pacing
   input wire logic slow,
   // command bytes
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   // reply bytes
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$];
   initial begin
      rx_data = 8'hff;
      rx_valid = 1'b0;
   end
   // a slow host takes a reply byte only every other cycle
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_ready <= 1'b0;
      end else begin
         tx_ready <= slow ? ~tx_ready : 1'b1;
         if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
         end
      end
   end
   // valid stays up across a line; afterwards the data shows the inverse so stale bytes never match
   task automatic send_str(input string s);
      for (int i = 0; i < s.len(); i++) begin
         rx_data <= s[i];
         rx_valid <= 1'b1;
         @(posedge clk);
         while (rx_ready !== 1'b1) begin
            @(posedge clk);
         end
      end
      rx_valid <= 1'b0;
      rx_data <= ~s[s.len()-1];
   endtask : send_str
endmodule : gsc_host_model

/* File: verification/tb_top.sv */
/*
 * self-checking bench of the command interpreter: bus accesses, command lines and replies.
 * assumes the host model and the design files are compiled before it.
 */
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [159:0] STAMP = "Mar 03 2003,01:02:03"; // arbitrary value
   localparam logic [55:0] REV = "REV0042"; // arbitrary value
   localparam logic [47:0] SID = "123456"; // arbitrary value
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic slow = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic wb_ack, rx_ready, rx_valid, tx_valid, tx_ready;
   logic [7:0] rx_data, tx_data;
   logic [gsc_pkg::NFLD-1:0][15:0] fld_val = {16'h000a, 16'h3039, 16'h0064, 16'h1234, 16'h0001,
      16'hffff, 16'h2710, 16'h0400, 16'h00c8};
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;
   initial begin
      forever #2.5 clk = ~clk;
   end
   gsc_cmd_top #(.FW_STAMP(STAMP), .FW_REV(REV), .SENSOR_ID(SID)) uut (.clk(clk), .arst_n(arst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(wb_ack), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .fld_val(fld_val));
   gsc_host_model u_host (.clk(clk), .arst_n(arst_n), .slow(slow), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready));
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      while (wb_ack !== 1'b1) begin
         @(posedge clk);
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wb_wr
   task automatic wb_rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      `CHK("register read", e, q)
   endtask : wb_rd
   // expected poll line: table order is highest weight first, five fields at most
   function automatic string q_line(input int m);
      int bits[9] = '{11, 10, 8, 7, 5, 4, 3, 2, 1};
      string ids = "dDhV00VZZ";
      string s = "";
      int n = 0;
      for (int i = 0; i < 9; i++) begin
         if (m[bits[i]] && n < 5) begin
            if (n > 0) begin
               s = {s, " "};
            end
            s = $sformatf("%s%c %05d", s, ids[i], fld_val[i]);
            n++;
         end
      end
      return {s, "\r\n"};
   endfunction : q_line
   // the trailing wait catches bytes sent beyond the expected reply
   task automatic run_cmd(input string c, input string e);
      int k = 0;
      u_host.got.delete();
      @(posedge clk);
      u_host.send_str(c);
      while ((u_host.got.size() < e.len() || rx_ready !== 1'b1) && k < 6000) begin
         @(posedge clk);
         k++;
      end
      repeat (30) @(posedge clk);
      `CHK("reply length", e.len(), u_host.got.size())
      for (int i = 0; i < e.len(); i++) `CHK("reply byte", e[i], u_host.got[i])
   endtask : run_cmd
   task automatic done(input string n);
      $display("test %s finished, mismatches %0d", n, n_mismatch);
   endtask : done
   task automatic t_reset_values();
      wb_rd(8'h00, 32'h0000_0006);
      wb_wr(8'h20, 32'h0000_1234);
      wb_rd(8'h20, 32'h0000_0000);
      wb_rd(8'h04, 32'h0000_2000);
      run_cmd("s\r\n", "s 08192\r\n");
      run_cmd("Q\r\n", q_line(6));
      done("reset_values");
   endtask : t_reset_values
   task automatic t_mask_fields();
      int m = 2048 + 1024 + 256 + 128 + 32;
      run_cmd($sformatf("M %0d\r\n", m), $sformatf("M %05d\r\n", m));
      wb_rd(8'h00, 32'(m));
      slow <= 1'b1;
      run_cmd("Q\r\n", q_line(m));
      slow <= 1'b0;
      run_cmd("M 56\r\n", "M 00056\r\n");
      run_cmd("Q\r\n", q_line(56));
      run_cmd("M 3518\r\n", "M 03518\r\n");
      run_cmd("Q\r\n", q_line(3518));
      run_cmd("M 0\r\n", "M 00000\r\n");
      run_cmd("Q\r\n", "\r\n");
      run_cmd("M 6\r\n", "M 00006\r\n");
      done("mask_fields");
   endtask : t_mask_fields
   task automatic t_bad_lines();
      run_cmd("x 12\r\n", "");
      run_cmd("M 123456\r\n", "");
      run_cmd("\r\n", "");
      // status: idle, not discarding, last accepted command char M
      wb_rd(8'h08, 32'h0000_4d00);
      wb_rd(8'h00, 32'h0000_0006);
      run_cmd("s\r\n", "s 08192\r\n");
      done("bad_lines");
   endtask : t_bad_lines
   task automatic t_compensation();
      wb_wr(8'h04, 32'h0001_1170);
      wb_rd(8'h04, 32'h0001_0000);
      run_cmd("s\r\n", "s 65536\r\n");
      run_cmd("S 100\r\n", "S 00100\r\n");
      wb_rd(8'h04, 32'h0000_0064);
      run_cmd("s\r\n", "s 00100\r\n");
      done("compensation");
   endtask : t_compensation
   task automatic t_identity();
      // measurement output is never streamed here, so the host counts as stopped
      run_cmd("Y\r\n", $sformatf("Y,%s,%s\r\nB %s 00000\r\n", STAMP, REV, SID));
      done("identity");
   endtask : t_identity
   // a second reset in mid-run must bring mask and compensation back to their defaults
   task automatic t_reset_again();
      wb_wr(8'h00, 32'h0000_0038);
      wb_wr(8'h04, 32'h0000_0064);
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      wb_rd(8'h00, 32'h0000_0006);
      wb_rd(8'h04, 32'h0000_2000);
      run_cmd("s\r\n", "s 08192\r\n");
      run_cmd("Q\r\n", q_line(6));
      done("reset_again");
   endtask : t_reset_again
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      t_reset_values();
      t_mask_fields();
      t_bad_lines();
      t_compensation();
      t_identity();
      t_reset_again();
      print_verdict();
   end
endmodule : tb_top
